// File: include/mtb_defs.vh
// Purpose: Constants for the multi-touch blocking and pattern detect block
// Assumes: 8-bit register port, 8 sensor inputs
// Notes:   Offsets are the register port addresses
`ifndef MTB_DEFS_VH
`define MTB_DEFS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define MTB_ADDR_GUARD     8'h29
`define MTB_ADDR_BLKCFG    8'h2A
`define MTB_ADDR_PATCFG    8'h2B
`define MTB_ADDR_PATMASK   8'h2D

// ----------------------------------------
// Reset values
// ----------------------------------------
`define MTB_RST_GUARD      8'h00
`define MTB_RST_BLKCFG     8'h80
`define MTB_RST_PATCFG     8'h00
`define MTB_RST_PATMASK    8'hFF

// ----------------------------------------
// Field positions
// ----------------------------------------
`define MTB_BLK_EN_BIT     7
`define MTB_BLK_LIM_HI     3
`define MTB_BLK_LIM_LO     2
`define MTB_PAT_EN_BIT     7
`define MTB_PAT_TH_HI      3
`define MTB_PAT_TH_LO      2
`define MTB_PAT_CMP_BIT    1
`define MTB_PAT_ALERT_BIT  0
`define MTB_FIVE_IDX       4

// Writable bits: guard has no bit for input five
`define MTB_MASK_GUARD     8'hEF
`define MTB_MASK_BLKCFG    8'h8C
`define MTB_MASK_PATCFG    8'h8F

`endif

// File: hw/mtb_input_eval.v
// Purpose: Per-input touch and pattern-threshold compare
// Assumes: Unsigned delta and threshold counts
// Notes:   Fraction of threshold is formed by shifts, no multiplier
`timescale 1ns/10ps
`default_nettype none

module mtb_input_eval
#(
   parameter W = 8
)
(
   // Front end values
   input  wire [W-1:0] delta,
   input  wire [W-1:0] thresh,
   input  wire         noise,
   input  wire         in_use,
   // Threshold fraction select
   input  wire [1:0]   frac_sel,
   // Results
   output reg          touch,
   output reg          over_pat
);

   reg [W+1:0] pat_th;

   always @*
   begin
      case (frac_sel)
         2'h0:    pat_th = {3'h0, thresh[W-1:1]} >> 2;
         2'h1:    pat_th = {2'h0, thresh} >> 2;
         2'h2:    pat_th = ({2'h0, thresh} + {1'b0, thresh, 1'b0}) >> 3;
         default: pat_th = {2'h0, thresh};
      endcase
      touch    = in_use && ({2'h0, delta} > {2'h0, thresh});
      over_pat = in_use && (({2'h0, delta} > pat_th) || noise);
   end

endmodule

`default_nettype wire

// File: hw/mtb_top.v
// Purpose: Multi-touch blocking and multi-touch pattern detection
// Assumes: Register port is a plain synchronous write/read strobe pair
// Notes:   Evaluation happens once per CYCLE_DONE pulse from the front end
//
// Notes on behaviour
// - Input five is unused whenever any guard enable bit is set.
// - Guard bits enable guard per input; reset zero; no bit four.
// - Blocking enabled (bit 7, reset 1) reports at most the limit.
// - Blocking disabled reports every detected touch.
// - Accepted inputs are remembered; others blocked until one releases.
// - After release, reselect first touches in order input one to eight.
// - Exceeding the limit with blocking sets the multi-touch flag.
// - Limit field bits 3:2 decode 00..11 as one to four touches.
// - Pattern detection runs only while its enable bit is set.
// - Pattern threshold fraction 12.5, 25, 37.5 or 100 percent.
// - Count mode: event when active count reaches mask popcount.
// - Pattern mode: event when every selected input is active.
// - Criteria judged within one sensing cycle only.
// - A pattern event blocks all touch reporting.
// - Blocking lasts while the condition holds, then touches resume.
// - Pattern flag clears by host write of zero only after condition ends.
// - Pattern flag sets regardless of alert enable.
// - Alert enable bit 0 lets a pattern event assert the alert.
// - Mask bit n selects input n+1; resets to all ones.
`timescale 1ns/10ps
`default_nettype none
`include "mtb_defs.vh"

module mtb_top
#(
   parameter N = 8,
   parameter W = 8
)
(
   // Clock and reset
   input  wire           CLK,
   input  wire           RESET,
   // Register port
   input  wire [7:0]     REG_ADDR,
   input  wire           REG_WR,
   input  wire [7:0]     REG_WDATA,
   input  wire           REG_RD,
   output reg  [7:0]     REG_RDATA,
   // Front end, one set per sensing cycle
   input  wire           CYCLE_DONE,
   input  wire [N*W-1:0] DELTA,
   input  wire [N*W-1:0] THRESH,
   input  wire [N-1:0]   NOISE,
   input  wire [N-1:0]   SENSOR_EN,
   // Status and flag clear
   input  wire           FLAG_CLR,
   output reg  [N-1:0]   TOUCH_REPORT,
   output reg            MULTI_TOUCH_FLAG,
   output reg            PATTERN_EVENT_FLAG,
   output reg            PATTERN_ALERT,
   output reg  [N-1:0]   GUARD_ENABLE,
   output reg            SENSOR_INPUT_FIVE_OFF
);

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   reg [7:0]   guard_q;
   reg [7:0]   blkcfg_q;
   reg [7:0]   patcfg_q;
   reg [7:0]   patmask_q;
   reg [N-1:0] accepted_q;
   reg         pat_cond_q;

   wire block_enable           = blkcfg_q[`MTB_BLK_EN_BIT];
   wire [1:0] simultaneous_touch_limit = blkcfg_q[`MTB_BLK_LIM_HI:`MTB_BLK_LIM_LO];
   wire pattern_detect_enable  = patcfg_q[`MTB_PAT_EN_BIT];
   wire [1:0] pattern_threshold_select = patcfg_q[`MTB_PAT_TH_HI:`MTB_PAT_TH_LO];
   wire pattern_compare_select = patcfg_q[`MTB_PAT_CMP_BIT];
   wire pattern_alert_enable   = patcfg_q[`MTB_PAT_ALERT_BIT];

   // ----------------------------------------
   // Register write
   // ----------------------------------------

   always @(posedge CLK or posedge RESET)
   begin
      if (RESET)
      begin
         guard_q   <= `MTB_RST_GUARD;
         blkcfg_q  <= `MTB_RST_BLKCFG;
         patcfg_q  <= `MTB_RST_PATCFG;
         patmask_q <= `MTB_RST_PATMASK;
      end
      else if (REG_WR)
      begin
         case (REG_ADDR)
            `MTB_ADDR_GUARD:   guard_q   <= REG_WDATA & `MTB_MASK_GUARD;
            `MTB_ADDR_BLKCFG:  blkcfg_q  <= REG_WDATA & `MTB_MASK_BLKCFG;
            `MTB_ADDR_PATCFG:  patcfg_q  <= REG_WDATA & `MTB_MASK_PATCFG;
            `MTB_ADDR_PATMASK: patmask_q <= REG_WDATA;
            default:           guard_q   <= guard_q;
         endcase
      end
   end

   // ----------------------------------------
   // Register read
   // ----------------------------------------
   // Read data registered one cycle after the strobe; unmapped reads zero
   always @(posedge CLK or posedge RESET)
   begin
      if (RESET)
         REG_RDATA <= 8'h00;
      else if (REG_RD)
      begin
         case (REG_ADDR)
            `MTB_ADDR_GUARD:   REG_RDATA <= guard_q;
            `MTB_ADDR_BLKCFG:  REG_RDATA <= blkcfg_q;
            `MTB_ADDR_PATCFG:  REG_RDATA <= patcfg_q;
            `MTB_ADDR_PATMASK: REG_RDATA <= patmask_q;
            default:           REG_RDATA <= 8'h00;
         endcase
      end
   end

   // ----------------------------------------
   // Per-input compare
   // ----------------------------------------
   wire         guard_any = |guard_q;
   wire [N-1:0] in_use;
   wire [N-1:0] touch_raw;
   wire [N-1:0] over_pat;

   genvar g;
   generate
      for (g = 0; g < N; g = g + 1)
      begin : g_in
         assign in_use[g] = SENSOR_EN[g] && !(g == `MTB_FIVE_IDX && guard_any);
         mtb_input_eval #(.W(W)) u_eval
         (
            .delta    (DELTA[g*W +: W]),
            .thresh   (THRESH[g*W +: W]),
            .noise    (NOISE[g]),
            .in_use   (in_use[g]),
            .frac_sel (pattern_threshold_select),
            .touch    (touch_raw[g]),
            .over_pat (over_pat[g])
         );
      end
   endgenerate

   // ----------------------------------------
   // Pattern criteria
   // ----------------------------------------
   reg [3:0]   mask_cnt;
   reg [3:0]   act_cnt;
   reg         pat_match;
   reg         pat_hit;
   integer     i;

   // Judged on this cycle's samples only, no history
   always @*
   begin
      mask_cnt = 4'h0;
      act_cnt  = 4'h0;
      for (i = 0; i < N; i = i + 1)
      begin
         mask_cnt = mask_cnt + {3'h0, patmask_q[i]};
         act_cnt  = act_cnt + {3'h0, over_pat[i]};
      end
      if (pattern_compare_select)
         pat_match = ((over_pat & patmask_q) == patmask_q);
      else
         pat_match = (act_cnt >= mask_cnt);
      // An empty mask in count mode always matches
      pat_hit = pat_match && pattern_detect_enable;
   end

   // ----------------------------------------
   // Touch acceptance
   // ----------------------------------------
   reg [3:0]   limit;
   reg [3:0]   kept_cnt;
   reg [3:0]   sel_cnt;
   reg [N-1:0] keep;
   reg         keep_all;
   reg [N-1:0] accept_d;
   reg         over_limit;
   integer     j;
   integer     k;

   // Accepted pads survive only while every one of them is still touched
   always @*
   begin
      keep     = accepted_q & touch_raw;
      keep_all = (keep == accepted_q) && (accepted_q != {N{1'b0}});
      if (!keep_all)
         keep = {N{1'b0}};
      kept_cnt = 4'h0;
      for (j = 0; j < N; j = j + 1)
         kept_cnt = kept_cnt + {3'h0, keep[j]};
   end

   // Free places go to the first new touches, input one first
   always @*
   begin
      limit      = {2'h0, simultaneous_touch_limit} + 4'h1;
      sel_cnt    = kept_cnt;
      over_limit = 1'b0;
      accept_d   = keep;
      for (k = 0; k < N; k = k + 1)
      begin
         if (touch_raw[k] && !keep[k])
         begin
            if (sel_cnt < limit)
            begin
               accept_d[k] = 1'b1;
               sel_cnt     = sel_cnt + 4'h1;
            end
            else
            begin
               over_limit = 1'b1;
            end
         end
      end
      if (!block_enable)
      begin
         accept_d   = touch_raw;
         over_limit = 1'b0;
      end
   end

   // ----------------------------------------
   // Per-cycle update
   // ----------------------------------------
   wire set_pat = CYCLE_DONE && pat_hit;
   // A clear counts only once the last judged cycle was free of the pattern
   wire clr_ok  = FLAG_CLR && !pat_cond_q;

   // Guard copies follow the register every clock
   always @(posedge CLK or posedge RESET)
   begin
      if (RESET)
      begin
         GUARD_ENABLE          <= {N{1'b0}};
         SENSOR_INPUT_FIVE_OFF <= 1'b0;
      end
      else
      begin
         GUARD_ENABLE          <= guard_q;
         SENSOR_INPUT_FIVE_OFF <= guard_any;
      end
   end

   always @(posedge CLK or posedge RESET)
   begin
      if (RESET)
      begin
         accepted_q       <= {N{1'b0}};
         pat_cond_q       <= 1'b0;
         TOUCH_REPORT     <= {N{1'b0}};
         MULTI_TOUCH_FLAG <= 1'b0;
      end
      else if (CYCLE_DONE)
      begin
         pat_cond_q <= pat_hit;
         if (pat_hit)
         begin
            TOUCH_REPORT <= {N{1'b0}};
            accepted_q   <= {N{1'b0}};
         end
         else
         begin
            TOUCH_REPORT     <= accept_d;
            accepted_q       <= block_enable ? accept_d : {N{1'b0}};
            MULTI_TOUCH_FLAG <= over_limit;
         end
      end
   end

   // ----------------------------------------
   // Pattern flag and alert
   // ----------------------------------------
   // Set beats clear; clear refused while condition still holds
   always @(posedge CLK or posedge RESET)
   begin
      if (RESET)
      begin
         PATTERN_EVENT_FLAG <= 1'b0;
         PATTERN_ALERT      <= 1'b0;
      end
      else
      begin
         if (set_pat)
            PATTERN_EVENT_FLAG <= 1'b1;
         else if (clr_ok)
            PATTERN_EVENT_FLAG <= 1'b0;
         if (set_pat && pattern_alert_enable)
            PATTERN_ALERT <= 1'b1;
         else if (clr_ok)
            PATTERN_ALERT <= 1'b0;
      end
   end

endmodule

`default_nettype wire

// File: sim/mtb_top_assertions.sv
// Purpose: Port-level checks on mtb_top
// Assumes: Outputs update on or one edge after the taking edge
// Notes:   Bound into every mtb_top instance
`timescale 1ns/10ps
`default_nettype none
module mtb_top_assertions
#(
   parameter N = 8,
   parameter W = 8
)
(
   input wire logic         CLK,
   input wire logic         RESET,
   input wire logic         CYCLE_DONE,
   input wire logic         FLAG_CLR,
   input wire logic [N-1:0] TOUCH_REPORT,
   input wire logic         MULTI_TOUCH_FLAG,
   input wire logic         PATTERN_EVENT_FLAG,
   input wire logic         PATTERN_ALERT,
   input wire logic [N-1:0] GUARD_ENABLE,
   input wire logic         SENSOR_INPUT_FIVE_OFF
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);
   // Two quiet cycles cover both one- and two-edge output latency
   sequence s_quiet;
      !CYCLE_DONE ##1 !CYCLE_DONE;
   endsequence
   sequence s_no_clr;
      !FLAG_CLR && !$past(FLAG_CLR);
   endsequence
   property p_bit4;
      GUARD_ENABLE[4] == 1'b0;
   endproperty
   property p_five;
      SENSOR_INPUT_FIVE_OFF == (GUARD_ENABLE != '0);
   endproperty
   property p_pat_blk;
      $rose(PATTERN_EVENT_FLAG) |-> TOUCH_REPORT == '0;
   endproperty
   property p_rise;
      $rose(PATTERN_EVENT_FLAG) |-> $past(CYCLE_DONE) || $past(CYCLE_DONE, 2);
   endproperty
   property p_hold;
      PATTERN_EVENT_FLAG ##0 s_no_clr |=> PATTERN_EVENT_FLAG;
   endproperty
   property p_alert;
      PATTERN_ALERT |-> PATTERN_EVENT_FLAG;
   endproperty
   property p_alert_clr;
      $fell(PATTERN_EVENT_FLAG) |-> !PATTERN_ALERT;
   endproperty
   property p_stand;
      s_quiet |=> $stable(TOUCH_REPORT);
   endproperty
   property p_lim;
      MULTI_TOUCH_FLAG |-> $countones(TOUCH_REPORT) <= 4;
   endproperty
   a_bit4: assert property (p_bit4) else $error("guard bit four set");
   a_five: assert property (p_five) else $error("input five state wrong");
   a_pat_blk: assert property (p_pat_blk) else $error("touch during pattern");
   a_rise: assert property (p_rise) else $error("flag set without cycle");
   a_hold: assert property (p_hold) else $error("flag lost without clear");
   a_alert: assert property (p_alert) else $error("alert without flag");
   a_alert_clr: assert property (p_alert_clr) else $error("alert kept");
   a_stand: assert property (p_stand) else $error("report moved");
   a_lim: assert property (p_lim) else $error("over four reported");
endmodule
bind mtb_top mtb_top_assertions #(.N(N), .W(W)) mtb_top_assertions_i (.*);
`default_nettype wire

// File: sim/mtb_host.sv
// Purpose: Host model on the register port
// Assumes: Strobes are taken at the edge after they are driven
// Notes:   Released write data is inverted so stale values never match
`timescale 1ns/10ps
`default_nettype none
module mtb_host
(
   input  wire logic       CLK,
   input  wire logic [7:0] REG_RDATA,
   output var logic  [7:0] REG_ADDR,
   output var logic  [7:0] REG_WDATA,
   output var logic        REG_WR,
   output var logic        REG_RD,
   output var logic        FLAG_CLR
);
   initial
   begin
      {REG_ADDR, REG_WDATA, REG_WR, REG_RD, FLAG_CLR} = '0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge CLK);
      {REG_ADDR, REG_WDATA, REG_WR} <= {a, d, 1'b1};
      @(posedge CLK);
      {REG_WDATA, REG_WR} <= {~d, 1'b0};
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge CLK);
      {REG_ADDR, REG_RD} <= {a, 1'b1};
      @(posedge CLK);
      REG_RD <= 1'b0;
      @(posedge CLK);
      #1 d = REG_RDATA;
   endtask
   // Host write of zero to the interrupt flag
   task automatic clr();
      @(posedge CLK);
      FLAG_CLR <= 1'b1;
      @(posedge CLK);
      FLAG_CLR <= 1'b0;
      @(posedge CLK);
      #1;
   endtask
endmodule
`default_nettype wire

// File: sim/mtb_top_bench.sv
// Purpose: Self-checking bench for mtb_top
// Assumes: Host model drives register port and flag clear
// Notes:   Expected values come from bench functions, tables and constants
`timescale 1ns/10ps
`default_nettype none
module mtb_top_bench;
   logic        CLK = 1'b0;
   logic        RESET = 1'b1;
   logic        CYCLE_DONE = 1'b0;
   logic [63:0] DELTA = '0;
   logic [63:0] THRESH = '0;
   logic [7:0]  NOISE = '0;
   logic [7:0]  SENSOR_EN = 8'hFF;
   wire  [7:0]  REG_ADDR, REG_WDATA, REG_RDATA, TOUCH_REPORT, GUARD_ENABLE;
   wire         REG_WR, REG_RD, FLAG_CLR, MULTI_TOUCH_FLAG;
   wire         PATTERN_EVENT_FLAG, PATTERN_ALERT, SENSOR_INPUT_FIVE_OFF;
   int          bad_count = 0;
   int          check_count = 0;
   logic [7:0]  ad [5] = '{8'h29, 8'h2A, 8'h2B, 8'h2D, 8'h2C};
   logic [7:0]  rv [5] = '{8'h00, 8'h80, 8'h00, 8'hFF, 8'h00};
   logic [7:0]  mk [5] = '{8'hEF, 8'h8C, 8'h8F, 8'hFF, 8'h00};
   logic [63:0] all = {8{8'hFF}};
   logic [63:0] lo = {8{8'h10}};
   mtb_host mtb_host_i (.*);
   mtb_top mtb_top_i (.*);
   initial forever #20 CLK = ~CLK;
   // ----------------------------------------
   // Checking helpers
   // ----------------------------------------
   task automatic cmp(input logic [7:0] g, input logic [7:0] e);
      check_count++;
      if (g !== e)
      begin
         $display("Error at %0t: got %h expected %h", $time, g, e);
         bad_count++;
      end
   endtask
   // Count mode needs the mask popcount; pattern mode needs every masked input
   function automatic logic hit(input logic [63:0] d, t, input logic [7:0] n, c, m);
      logic [7:0]  a;
      logic [10:0] f;
      for (int k = 0; k < 8; k++)
      begin
         f = t[k*8+:8];
         f = c[3:2] == 0 ? f >> 3 : c[3:2] == 1 ? f >> 2 : c[3:2] == 2 ? (f * 3) >> 3 : f;
         a[k] = n[k] | (d[k*8+:8] > f);
      end
      return c[1] ? (a & m) == m : $countones(a) >= $countones(m);
   endfunction
   // Touch is a delta strictly above its own threshold
   function automatic logic [7:0] tch(input logic [63:0] d, t);
      logic [7:0] v;
      for (int k = 0; k < 8; k++)
         v[k] = d[k*8+:8] > t[k*8+:8];
      return v;
   endfunction
   task automatic cyc(input logic [63:0] d, t, input logic [7:0] n);
      @(posedge CLK);
      {DELTA, THRESH, NOISE, CYCLE_DONE} <= {d, t, n, 1'b1};
      @(posedge CLK);
      {DELTA, CYCLE_DONE} <= {~d, 1'b0};
      repeat (2) @(posedge CLK);
      #1;
   endtask
   task final_report();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      #800000;
      bad_count++;
      final_report();
   end
   initial
   begin
      logic [7:0]  r, c, m, x;
      logic [63:0] d, t;
      logic        h;
      x = $urandom(32'h3C1B);
      repeat (8) @(posedge CLK);
      RESET <= 1'b0;
      for (int i = 0; i < 5; i++)
      begin
         mtb_host_i.rd(ad[i], r);
         cmp(r, rv[i]);
         x = $urandom;
         mtb_host_i.wr(ad[i], x);
         mtb_host_i.rd(ad[i], r);
         cmp(r, x & mk[i]);
         mtb_host_i.wr(ad[i], rv[i]);
      end
      $display("register test done");
      for (int l = 0; l < 4; l++)
      begin
         mtb_host_i.wr(8'h2A, 8'h80 | (l << 2));
         cyc('0, lo, '0);
         cmp(MULTI_TOUCH_FLAG, 0);
         cyc(all, lo, '0);
         cmp(TOUCH_REPORT, (2 << l) - 1);
         cmp(MULTI_TOUCH_FLAG, 1);
      end
      mtb_host_i.wr(8'h2A, 8'h80);
      cyc(64'hFF00, lo, '0);
      cyc(64'hFFFF, lo, '0);
      cmp(TOUCH_REPORT, 8'h02);
      cyc(64'hFF00FF, lo, '0);
      cmp(TOUCH_REPORT, 8'h01);
      mtb_host_i.wr(8'h2A, 8'h00);
      cyc(all, lo, '0);
      cmp(TOUCH_REPORT, 8'hFF);
      cmp(MULTI_TOUCH_FLAG, 0);
      cmp(PATTERN_EVENT_FLAG, 0);
      x = $urandom;
      @(posedge CLK) SENSOR_EN <= x;
      cyc(all, lo, '0);
      cmp(TOUCH_REPORT, x);
      @(posedge CLK) SENSOR_EN <= 8'hFF;
      $display("blocking test done");
      repeat (40)
      begin
         c = 8'h80 | ($urandom & 8'h0F);
         m = $urandom | 8'h81;
         mtb_host_i.wr(8'h2B, c);
         mtb_host_i.wr(8'h2D, m);
         d = {$urandom, $urandom};
         t = {$urandom, $urandom};
         r = $urandom & $urandom & $urandom;
         cyc(d, t, r);
         h = hit(d, t, r, c, m);
         cmp(PATTERN_EVENT_FLAG, h);
         cmp(PATTERN_ALERT, h & c[0]);
         if (h)
         begin
            cmp(TOUCH_REPORT, 0);
            mtb_host_i.clr();
            cmp(PATTERN_EVENT_FLAG, 1);
         end
         else
            cmp(TOUCH_REPORT, tch(d, t));
         cyc(64'hFF, lo, '0);
         cmp(TOUCH_REPORT, 1);
         mtb_host_i.clr();
         cmp(PATTERN_EVENT_FLAG, 0);
      end
      $display("pattern test done");
      mtb_host_i.wr(8'h29, 8'hFF);
      mtb_host_i.wr(8'h2B, 8'h00);
      cyc(all, lo, '0);
      cmp(GUARD_ENABLE, 8'hEF);
      cmp(SENSOR_INPUT_FIVE_OFF, 1);
      cmp(TOUCH_REPORT, 8'hEF);
      $display("guard test done");
      final_report();
   end
endmodule
`default_nettype wire
